// [design/crrc_top.sv]
// CPU runaway reset counter: watchdog that resets the core when not cleared.
`timescale 1ns/100ps
`default_nettype none

module crrc_top
  import crrc_pkg::*;
#(
  parameter int COUNT_WIDTH  = CRRC_COUNT_WIDTH,
  parameter int OSC_DIVIDE   = CRRC_OSC_DIVIDE,
  parameter int PULSE_CYCLES = CRRC_RESET_PULSE_CYCLES,
  parameter int GRACE_CYCLES = CRRC_GRACE_CYCLES
) (
  // System clock and power-on reset.
  input  wire logic                   CLK_SYS,
  input  wire logic                   RESET,
  // Machine clock enable from the clock generator.
  input  wire logic                   MACHINE_TICK,
  // Write strobe and data of the clear bit in the voltage reset control register.
  input  wire logic                   CLEAR_WRITE,
  input  wire logic                   RUNAWAY_COUNTER_CLEAR_BIT,
  // Clearing causes from the rest of the device.
  input  wire logic                   INTERNAL_RESET_IN,
  input  wire logic                   OSC_STOPPED,
  input  wire logic                   ENTER_SLEEP,
  input  wire logic                   ENTER_TIMEBASE,
  input  wire logic                   ENTER_WATCH,
  // Operating conditions.
  input  wire logic                   CPU_HALTED,
  input  wire logic                   STANDBY_RECOVERY,
  // Results.
  output var  logic                   RUNAWAY_RESET,
  output var  logic                   GRACE_ACTIVE,
  output var  logic [COUNT_WIDTH-1:0] RUNAWAY_COUNT
);

  // Widths and end points of the three counters. The all-ones count is the
  // last value of the interval; the next tick wraps it and raises the reset, or the extension in standby recovery.
  localparam int PW = (PULSE_CYCLES > 1) ? $clog2(PULSE_CYCLES) : 1;
  localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYCLES - 1);
  localparam logic [CRRC_GRACE_WIDTH-1:0] GRACE_LAST = CRRC_GRACE_WIDTH'(GRACE_CYCLES - 1);
  localparam logic [COUNT_WIDTH-1:0] COUNT_FULL = '1;

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillation clock enable.

  logic osc_tick;

  // The oscillation clock only runs while the main oscillator runs. Its
  // period is the only link to the real oscillator: change OSC_DIVIDE with
  // the system clock so that the interval stays 2^20 oscillation periods.
  crrc_tick_divider #(
    .DIVIDE (OSC_DIVIDE)
  ) u_osc_div (
    .clk    (CLK_SYS),
    .reset  (RESET),
    .enable (!OSC_STOPPED),
    .tick   (osc_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clearing causes.

  logic write_clear;
  logic reset_clear;
  logic mode_clear;
  logic clear_event;
  logic count_step;
  logic grace_step;

  // Software clear. Only a write of the clear value restarts the count; a
  // write of the other value leaves the interval running, so code that
  // rewrites the whole control register does not feed the watchdog by accident.
  assign write_clear = CLEAR_WRITE && (RUNAWAY_COUNTER_CLEAR_BIT == CRRC_CLEAR_VALUE);

  // Device-level causes. A stopped oscillator also freezes the tick divider,
  // so the count cannot creep on once the clear has been applied.
  assign reset_clear = INTERNAL_RESET_IN || OSC_STOPPED;

  // Entry to any of the low-power modes.
  assign mode_clear = ENTER_SLEEP || ENTER_TIMEBASE || ENTER_WATCH;

  // Any of these restarts the count from zero. Causes may be levels or pulses:
  // a level simply keeps the count at zero for as long as it stands.
  assign clear_event = write_clear || reset_clear || mode_clear;

  ////////////////////////////////////////////////////////////////////////////////
  // Advance qualifiers.

  // The count moves only on an oscillation tick while the CPU runs. The
  // extension is timed in system cycles and freezes with the CPU as well,
  // so a halt in the middle of the extension only postpones the reset.
  assign count_step = osc_tick && !CPU_HALTED;
  assign grace_step = !CPU_HALTED;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  crrc_state_type                state_reg;
  crrc_state_type                state_next;
  logic [COUNT_WIDTH-1:0]        count_reg;
  logic [COUNT_WIDTH-1:0]        count_next;
  logic [CRRC_GRACE_WIDTH-1:0]   grace_reg;
  logic [CRRC_GRACE_WIDTH-1:0]   grace_next;
  logic [PW-1:0]                 pulse_reg;
  logic [PW-1:0]                 pulse_next;

  // End points of the three counters. The pulse ends on the machine tick
  // that completes its last machine cycle.
  logic count_wrap;
  logic grace_done;
  logic pulse_done;

  assign count_wrap = (count_reg == COUNT_FULL);
  assign grace_done = (grace_reg == GRACE_LAST);
  assign pulse_done = MACHINE_TICK && (pulse_reg == PULSE_LAST);

  // Next-state logic. The timeout pulse ignores clear causes: our own reset
  // usually comes back as an internal reset, and it must not cut the pulse.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    grace_next = grace_reg;
    pulse_next = pulse_reg;
    case (state_reg)
      CRRC_COUNTING: begin
        if (clear_event) begin
          count_next = '0;
        // A clear beats an increment in the same cycle, so a clear that lands
        // on the cycle of a tick still buys a full interval.
        end else if (count_step) begin
          if (count_wrap) begin
            // Wrap from all ones means the interval ran out uncleared.
            count_next = '0;
            grace_next = '0;
            pulse_next = '0;
            if (STANDBY_RECOVERY) begin
              state_next = CRRC_GRACE;
            end else begin
              state_next = CRRC_PULSE;
            end
          end else begin
            count_next = count_reg + COUNT_WIDTH'(1);
          end
        end
      end
      CRRC_GRACE: begin
        // Extension of the interval while leaving standby.
        if (clear_event) begin
          state_next = CRRC_COUNTING;
          count_next = '0;
        // Reaching the end of the extension uncleared is a timeout.
        end else if (grace_step) begin
          if (grace_done) begin
            state_next = CRRC_PULSE;
            pulse_next = '0;
          end else begin
            grace_next = grace_reg + CRRC_GRACE_WIDTH'(1);
          end
        end
      end
      CRRC_PULSE: begin
        // Count machine cycles of the reset pulse, counter held at zero.
        // Clear causes are not looked at here: our own reset returns as an
        // internal reset, and that echo must not shorten the pulse.
        count_next = '0;
        if (pulse_done) begin
          state_next = CRRC_COUNTING;
        end else if (MACHINE_TICK) begin
          pulse_next = pulse_reg + PW'(1);
        end
      end
      default: begin
        state_next = CRRC_COUNTING;
        count_next = '0;
      end
    endcase
  end

  // Register the sequencer. Reset release leaves it counting, so no software
  // enable is needed after power-on.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_reg <= CRRC_COUNTING;
      count_reg <= '0;
      grace_reg <= '0;
      pulse_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      grace_reg <= grace_next;
      pulse_reg <= pulse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // Outputs follow the next state so they line up with the state register.
  // Registering them keeps decode glitches off the reset request, which
  // reaches the whole device.
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      RUNAWAY_RESET <= 1'b0;
      GRACE_ACTIVE  <= 1'b0;
      RUNAWAY_COUNT <= '0;
    end else begin
      RUNAWAY_RESET <= (state_next == CRRC_PULSE);
      GRACE_ACTIVE  <= (state_next == CRRC_GRACE);
      RUNAWAY_COUNT <= count_next;
    end
  end

endmodule // crrc_top

`default_nettype wire

// [design/crrc_pkg.sv]
// Constants and types shared by the CPU runaway reset counter files.
`default_nettype none
package crrc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock rates and the divider that makes the oscillation clock enable.
  localparam int CRRC_SYS_PERIOD_NS = 5;
  localparam int CRRC_SYS_FREQ_HZ   = 200_000_000;
  localparam int CRRC_OSC_FREQ_HZ   = 4_000_000;
  localparam int CRRC_OSC_DIVIDE    = CRRC_SYS_FREQ_HZ / CRRC_OSC_FREQ_HZ;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter size, reset pulse width and the standby recovery extension.
  localparam int CRRC_COUNT_WIDTH        = 20;
  localparam int CRRC_RESET_PULSE_CYCLES = 5;
  localparam int CRRC_GRACE_TIME_NS      = 20_000;
  // A least time, so the cycle count rounds up.
  localparam int CRRC_GRACE_CYCLES =
    (CRRC_GRACE_TIME_NS + CRRC_SYS_PERIOD_NS - 1) / CRRC_SYS_PERIOD_NS;
  localparam int CRRC_GRACE_WIDTH = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // Value of the clear bit that restarts the counter when written.
  localparam logic CRRC_CLEAR_VALUE = 1'b0;

  // Sequencer states.
  typedef enum logic [1:0] {
    CRRC_COUNTING,
    CRRC_GRACE,
    CRRC_PULSE
  } crrc_state_type;

endpackage

`default_nettype wire

// [design/crrc_tick_divider.sv]
// Divider that turns the system clock into a one-cycle enable pulse.
`timescale 1ns/100ps
`default_nettype none

module crrc_tick_divider
  import crrc_pkg::*;
#(
  parameter int DIVIDE = CRRC_OSC_DIVIDE
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Divider control and output.
  input  wire logic enable,
  output var  logic tick
);

  localparam int CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  logic [CW-1:0] div_reg;
  logic [CW-1:0] div_next;
  logic          tick_next;

  // Count up the period; the pulse marks the wrap. Holding when disabled
  // keeps a stopped oscillator from producing ticks.
  always_comb begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (enable) begin
      if (div_reg == LAST) begin
        div_next  = '0;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + CW'(1);
      end
    end
  end

  // Register the divider state.
  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= '0;
      tick    <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick    <= tick_next;
    end
  end

endmodule // crrc_tick_divider

`default_nettype wire

// [verification/crrc_top_monitor.sv]
// Checker of the CPU runaway reset counter ports.
`timescale 1ns/100ps
`default_nettype none
module crrc_top_monitor #(
  parameter int COUNT_WIDTH  = 20,
  parameter int PULSE_CYCLES = 5
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RESET,
  // Inputs of the counter.
  input wire logic MACHINE_TICK,
  input wire logic CLEAR_WRITE,
  input wire logic RUNAWAY_COUNTER_CLEAR_BIT,
  input wire logic INTERNAL_RESET_IN,
  input wire logic OSC_STOPPED,
  input wire logic ENTER_SLEEP,
  input wire logic ENTER_TIMEBASE,
  input wire logic ENTER_WATCH,
  input wire logic CPU_HALTED,
  input wire logic STANDBY_RECOVERY,
  // Results.
  input wire logic RUNAWAY_RESET,
  input wire logic GRACE_ACTIVE,
  input wire logic [COUNT_WIDTH-1:0] RUNAWAY_COUNT
);
  logic       cause;
  logic [3:0] tick_reg;
  logic [3:0] tick_next;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////////////
  // Any clearing cause, and machine ticks counted while the pulse is high.
  assign cause = INTERNAL_RESET_IN | OSC_STOPPED | ENTER_SLEEP | ENTER_TIMEBASE | ENTER_WATCH
               | (CLEAR_WRITE & ~RUNAWAY_COUNTER_CLEAR_BIT);
  always_comb tick_next = RUNAWAY_RESET ? tick_reg + {3'h0, MACHINE_TICK} : 4'h0;
  always_ff @(posedge CLK_SYS) tick_reg <= RESET ? 4'h0 : tick_next;
  ////////////////////////////////////////////////////////////////////////////////
  // The pulse ignores clears, so every clear property excludes it.
  property p_clear;
    CLEAR_WRITE && !RUNAWAY_COUNTER_CLEAR_BIT && !RUNAWAY_RESET |=> RUNAWAY_COUNT == '0; endproperty
  property p_cause;
    cause && !RUNAWAY_RESET |=> RUNAWAY_COUNT == '0; endproperty
  property p_halt;
    CPU_HALTED && !cause && !RUNAWAY_RESET |=> $stable(RUNAWAY_COUNT) && !$rose(RUNAWAY_RESET);
  endproperty
  property p_step;
    $changed(RUNAWAY_COUNT) |->
      RUNAWAY_COUNT == '0 || RUNAWAY_COUNT == COUNT_WIDTH'($past(RUNAWAY_COUNT) + 1'b1);
  endproperty
  property p_wrap;
    $past(RUNAWAY_COUNT) == '1 && RUNAWAY_COUNT == '0 && !$past(cause) && !$past(CPU_HALTED)
      |-> ($past(STANDBY_RECOVERY) ? GRACE_ACTIVE : RUNAWAY_RESET); endproperty
  property p_pulse_len;
    RUNAWAY_RESET |-> tick_reg < PULSE_CYCLES; endproperty
  property p_pulse_end;
    $fell(RUNAWAY_RESET) |-> tick_reg == PULSE_CYCLES; endproperty
  property p_grace_end;
    $fell(GRACE_ACTIVE) && !$past(cause) |-> ##[0:1] RUNAWAY_RESET; endproperty
  a_clear: assert property (p_clear) else $error("clear write ignored");
  a_cause: assert property (p_cause) else $error("clear cause ignored");
  a_halt: assert property (p_halt) else $error("count moved while halted");
  a_step: assert property (p_step) else $error("count skipped");
  a_wrap: assert property (p_wrap) else $error("wrap without reset");
  a_pulse_len: assert property (p_pulse_len) else $error("pulse too long");
  a_pulse_end: assert property (p_pulse_end) else $error("pulse too short");
  a_grace_end: assert property (p_grace_end) else $error("no reset after grace");
  c_pulse: cover property ($rose(RUNAWAY_RESET));
  c_grace: cover property ($rose(GRACE_ACTIVE));
  c_halt: cover property (CPU_HALTED && RUNAWAY_COUNT != '0);
endmodule // crrc_top_monitor
bind crrc_top crrc_top_monitor #(.COUNT_WIDTH(COUNT_WIDTH), .PULSE_CYCLES(PULSE_CYCLES))
  u_crrc_top_monitor (.CLK_SYS, .RESET, .MACHINE_TICK, .CLEAR_WRITE, .RUNAWAY_COUNTER_CLEAR_BIT,
  .INTERNAL_RESET_IN, .OSC_STOPPED, .ENTER_SLEEP, .ENTER_TIMEBASE, .ENTER_WATCH, .CPU_HALTED,
  .STANDBY_RECOVERY, .RUNAWAY_RESET, .GRACE_ACTIVE, .RUNAWAY_COUNT);
`default_nettype wire

// [verification/test_crrc_top.sv]
// Self-checking testbench of the CPU runaway reset counter.
`timescale 1ns/100ps
`default_nettype none
module test_crrc_top;
  import crrc_pkg::*;
  localparam int W = 4;
  localparam int DIV = 2;
  localparam int GRACE = 8;
  localparam int IVL = (2 ** W) * DIV;
  logic clk = 1'b0, rst = 1'b1, tick = 1'b0, cw = 1'b0, cb = 1'b1, halt = 1'b0, stby = 1'b0;
  logic [4:0] cause = 5'h00;
  logic rr, ga;
  logic [W-1:0] cnt;
  int fails = 0, num_checks = 0, cyc = 0, n, m;
  // Short counts keep the full interval at a few dozen cycles.
  crrc_top #(.COUNT_WIDTH(W), .OSC_DIVIDE(DIV), .GRACE_CYCLES(GRACE)) u_crrc_top (
    .CLK_SYS(clk), .RESET(rst), .MACHINE_TICK(tick), .CLEAR_WRITE(cw),
    .RUNAWAY_COUNTER_CLEAR_BIT(cb), .INTERNAL_RESET_IN(cause[4]), .OSC_STOPPED(cause[3]),
    .ENTER_SLEEP(cause[2]), .ENTER_TIMEBASE(cause[1]), .ENTER_WATCH(cause[0]),
    .CPU_HALTED(halt), .STANDBY_RECOVERY(stby), .RUNAWAY_RESET(rr), .GRACE_ACTIVE(ga),
    .RUNAWAY_COUNT(cnt));
  // Clock, a machine tick every fourth cycle and a ceiling against hangs.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    tick <= (cyc % 4 == 3);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Lets the edge's updates land before sampling.
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic clear(input logic bit_val);
    @(posedge clk) cw <= 1'b1;
    cb <= bit_val;
    @(posedge clk) cw <= 1'b0;
    cb <= 1'b1;
    #1;
  endtask
  task automatic t_clears();
    clear(1'b0);
    chk("clear", cnt, 0);
    step(6);
    clear(1'b1);
    chk("clear one", cnt != 0, 1);
    for (int k = 0; k < 5; k++) begin
      step(6);
      @(posedge clk) cause <= 5'h10 >> k;
      @(posedge clk) cause <= 5'h00;
      #1;
      chk("cause", cnt, 0);
    end
  endtask
  task automatic t_halt();
    @(posedge clk) halt <= 1'b1;
    step(2);
    m = cnt;
    step(IVL + 8);
    chk("halt count", cnt, m);
    chk("halt reset", rr, 0);
    @(posedge clk) halt <= 1'b0;
  endtask
  task automatic t_timeout();
    clear(1'b0);
    for (n = 0; rr !== 1'b1 && n < 60; n++) step(1);
    chk("interval", n >= IVL - 2 && n <= IVL + 3, 1);
    chk("wrap count", cnt, 0);
    m = 0;
    for (n = 0; rr === 1'b1 && n < 100; n++) begin
      m += (tick === 1'b1);
      step(1);
    end
    chk("pulse ticks", m, CRRC_RESET_PULSE_CYCLES);
    chk("restart", cnt, 0);
  endtask
  task automatic t_grace();
    @(posedge clk) stby <= 1'b1;
    clear(1'b0);
    for (n = 0; ga !== 1'b1 && n < 60; n++) step(1);
    chk("grace", {ga, rr}, 2'h2);
    for (m = 0; ga === 1'b1 && m < 40; m++) step(1);
    chk("grace length", m, GRACE);
    for (n = 0; rr !== 1'b1 && n < 3; n++) step(1);
    chk("grace reset", rr, 1);
    @(posedge clk) stby <= 1'b0;
    #1;
    for (n = 0; rr === 1'b1 && n < 100; n++) step(1);
    chk("grace pulse end", rr, 0);
  endtask
  // Clears spaced well inside the interval never let the count run out.
  task automatic t_keepalive();
    for (int k = 0; k < 4; k++) begin
      clear(1'b0);
      step(IVL - 8);
      chk("kept count", cnt, (IVL - 8) / DIV);
      chk("kept alive", rr, 0);
    end
  endtask
  // A second reset in mid-run; counting must start again by itself.
  task automatic t_reset();
    step(10);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chk("reset again", {rr, ga, cnt}, 0);
    step(12);
    chk("restarts", cnt != 0, 1);
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chk("reset", {rr, ga, cnt}, 0);
    step(12);
    chk("starts", cnt != 0, 1);
    t_clears();
    t_keepalive();
    t_halt();
    t_timeout();
    t_grace();
    t_reset();
    complete_run();
  end
endmodule // test_crrc_top
`default_nettype wire
